//--- core/hssps_pin_select.sv
// Strap capture, shared serial pin routing and status pin reuse for the hub.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Port 4 over-current input low means event, high means none.
// - Ganged mode accepts over-current from any one wired input; unused inputs idle high.
// - Clock pin serves the I2C EEPROM when strap is 1, SMBus host when 0.
// - Data pin serves the I2C EEPROM when strap is 1, SMBus host when 0.
// - Serial mode strap sampled at reset release: 1 is I2C, 0 is SMBus.
// - With status output enabled, serial mode pin drives suspend status, 1 suspended.
// - Power-management strap sampled at release: 0 enables switching and over-current.
// - Power-management strap sampled 1 marks switching and over-current unsupported.
// - With status output enabled, power-management pin drives high on SuperSpeed link.
// - In SMBus mode the power-management strap level gives slave address bit 1.
module hssps_pin_select
  import hssps_pkg::*;
#(
  parameter int OTHER_OC = OTHER_OC_INPUTS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Serial mode strap and suspend status pin.
  input wire logic serialModeSelectNIn,
  output logic serialModeSelectNOut,
  output logic serialModeSelectNOe,
  // Full power-management strap and SuperSpeed connection status pin.
  input wire logic fullPowerMgmtNIn,
  output logic fullPowerMgmtNOut,
  output logic fullPowerMgmtNOe,
  // Shared serial clock pin, open drain.
  input wire logic sharedSerialClockPinIn,
  output logic sharedSerialClockPinOut,
  output logic sharedSerialClockPinOe,
  // Shared serial data pin, open drain.
  input wire logic sharedSerialDataPinIn,
  output logic sharedSerialDataPinOut,
  output logic sharedSerialDataPinOe,
  // Over-current pins, active low.
  input wire logic port4OvercurrentN,
  input wire logic [OTHER_OC-1:0] portOvercurrentN,
  // EEPROM master side: pull-low requests and received pin levels.
  input wire logic eepromClkPullLow,
  input wire logic eepromDatPullLow,
  output logic eepromClkSeen,
  output logic eepromDatSeen,
  // SMBus slave side: pull-low requests and received pin levels.
  input wire logic smbusClkPullLow,
  input wire logic smbusDatPullLow,
  output logic smbusClkSeen,
  output logic smbusDatSeen,
  // Hub core status and configuration.
  input wire logic statusOutputEnable,
  input wire logic gangedEnable,
  input wire logic upstreamSsSuspended,
  input wire logic upstreamSsConnected,
  // Captured configuration.
  output logic strapsValid,
  output logic i2cModeSelected,
  output logic powerSwitchEnabled,
  output logic smbusAddrBit1Strap,
  // Over-current report, active high.
  output logic port4Overcurrent,
  output logic gangedOvercurrent,
  output logic overcurrentEvent
);

  if (OTHER_OC < 1) begin : g_bad_other_oc
    $error("hssps_pin_select needs at least one other over-current input");
  end

  typedef struct packed {
    hssps_phase_t phase;
    hssps_strap_t strap;
    hssps_oc_t oc;
    hssps_pin_drive_t modePin;
    hssps_pin_drive_t pmPin;
    logic eepromClk;
    logic eepromDat;
    logic smbusClk;
    logic smbusDat;
  } hssps_state_t;

  localparam int SYNC_W = 5 + OTHER_OC;

  hssps_state_t state_r;
  hssps_state_t state_nxt;
  logic [SYNC_W-1:0] pinsAsync;
  logic [SYNC_W-1:0] pinsSync;
  logic modeSync;
  logic pmSync;
  logic clkSync;
  logic datSync;
  logic oc4Sync;
  logic [OTHER_OC-1:0] ocOtherSync;

  // Over-current is only meaningful when power switching was strapped on.
  function automatic logic oc_active(input logic pinLevel, input logic pmN);
    oc_active = (pinLevel == OVERCURRENT_ASSERTED) && (pmN == FULL_PM_ENABLED);
  endfunction

  assign pinsAsync = {portOvercurrentN, port4OvercurrentN, sharedSerialDataPinIn,
                      sharedSerialClockPinIn, fullPowerMgmtNIn, serialModeSelectNIn};

  hssps_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .asyncIn(pinsAsync),
    .syncOut(pinsSync)
  );

  assign modeSync = pinsSync[0];
  assign pmSync = pinsSync[1];
  assign clkSync = pinsSync[2];
  assign datSync = pinsSync[3];
  assign oc4Sync = pinsSync[4];
  assign ocOtherSync = pinsSync[SYNC_W-1:5];

  always_comb begin
    state_nxt = state_r;
    state_nxt.oc.newEvent = 1'h0;
    case (state_r.phase)
      PH_STRAP: begin
        // First cycle after release: the synchronised pins still carry the
        // pad levels because neither strap pin is driven during reset.
        state_nxt.strap.i2cMode = (modeSync == SERIAL_MODE_I2C);
        state_nxt.strap.fullPmN = pmSync;
        state_nxt.strap.smbAddrBit1 = pmSync;
        state_nxt.phase = PH_RUN;
      end
      PH_RUN: begin
        // Straps are left untouched here, so later pin reuse cannot alter them.
        state_nxt.oc.port4Active = oc_active(oc4Sync, state_r.strap.fullPmN);
        // Unwired inputs sit high through their pull-ups, so any single low
        // input reports the shared fault.
        state_nxt.oc.gangedActive = gangedEnable &&
          oc_active(oc4Sync & (&ocOtherSync), state_r.strap.fullPmN);
        state_nxt.oc.newEvent =
          (state_nxt.oc.port4Active && !state_r.oc.port4Active) ||
          (state_nxt.oc.gangedActive && !state_r.oc.gangedActive);
        state_nxt.modePin.oe = statusOutputEnable;
        state_nxt.modePin.out = upstreamSsSuspended ? STATUS_ACTIVE : ~STATUS_ACTIVE;
        state_nxt.pmPin.oe = statusOutputEnable;
        state_nxt.pmPin.out = upstreamSsConnected ? STATUS_ACTIVE : ~STATUS_ACTIVE;
      end
      default: begin
        state_nxt.phase = PH_STRAP;
      end
    endcase
    // Received levels go only to the side that owns the pins; the idle side
    // sees a released (high) bus so it never decodes stray traffic.
    state_nxt.eepromClk = state_r.strap.i2cMode ? clkSync : 1'h1;
    state_nxt.eepromDat = state_r.strap.i2cMode ? datSync : 1'h1;
    state_nxt.smbusClk = state_r.strap.i2cMode ? 1'h1 : clkSync;
    state_nxt.smbusDat = state_r.strap.i2cMode ? 1'h1 : datSync;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r.phase <= PH_STRAP;
      state_r.strap.i2cMode <= SERIAL_MODE_RESET;
      state_r.strap.fullPmN <= FULL_PM_RESET;
      state_r.strap.smbAddrBit1 <= FULL_PM_RESET;
      state_r.oc <= '0;
      state_r.modePin <= '0;
      state_r.pmPin <= '0;
      state_r.eepromClk <= 1'h1;
      state_r.eepromDat <= 1'h1;
      state_r.smbusClk <= 1'h1;
      state_r.smbusDat <= 1'h1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shared pins are open drain: they only ever pull low, and only for the
  // side that the strap selected. Nothing drives them before capture.
  always_comb begin
    sharedSerialClockPinOut = OPEN_DRAIN_LOW;
    sharedSerialDataPinOut = OPEN_DRAIN_LOW;
    sharedSerialClockPinOe = 1'h0;
    sharedSerialDataPinOe = 1'h0;
    if (state_r.phase == PH_RUN) begin
      if (state_r.strap.i2cMode) begin
        sharedSerialClockPinOe = eepromClkPullLow;
        sharedSerialDataPinOe = eepromDatPullLow;
      end else begin
        sharedSerialClockPinOe = smbusClkPullLow;
        sharedSerialDataPinOe = smbusDatPullLow;
      end
    end
  end

  assign serialModeSelectNOut = state_r.modePin.out;
  assign serialModeSelectNOe = state_r.modePin.oe;
  assign fullPowerMgmtNOut = state_r.pmPin.out;
  assign fullPowerMgmtNOe = state_r.pmPin.oe;

  assign eepromClkSeen = state_r.eepromClk;
  assign eepromDatSeen = state_r.eepromDat;
  assign smbusClkSeen = state_r.smbusClk;
  assign smbusDatSeen = state_r.smbusDat;

  assign strapsValid = (state_r.phase == PH_RUN);
  assign i2cModeSelected = state_r.strap.i2cMode;
  assign powerSwitchEnabled = (state_r.strap.fullPmN == FULL_PM_ENABLED);
  // The address bit only means something on the SMBus side.
  assign smbusAddrBit1Strap = state_r.strap.smbAddrBit1 & ~state_r.strap.i2cMode;

  assign port4Overcurrent = state_r.oc.port4Active;
  assign gangedOvercurrent = state_r.oc.gangedActive;
  assign overcurrentEvent = state_r.oc.newEvent;

endmodule
`default_nettype wire

//--- core/hssps_pkg.sv
// Shared constants and carrier types for the hub strap and serial pin select block.
package hssps_pkg;

  // Strap levels and their meaning.
  localparam logic SERIAL_MODE_I2C = 1'h1;
  localparam logic SERIAL_MODE_SMBUS = 1'h0;
  localparam logic FULL_PM_ENABLED = 1'h0;
  localparam logic FULL_PM_UNSUPPORTED = 1'h1;

  // Pin levels.
  localparam logic OVERCURRENT_ASSERTED = 1'h0;
  localparam logic STATUS_ACTIVE = 1'h1;
  localparam logic OPEN_DRAIN_LOW = 1'h0;

  // Reset values of captured straps, matching the pad pulls.
  localparam logic SERIAL_MODE_RESET = 1'h1;
  localparam logic FULL_PM_RESET = 1'h0;

  // Default number of extra ganged over-current inputs besides port 4.
  localparam int OTHER_OC_INPUTS = 3;

  // Synchroniser depth.
  localparam int SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    PH_STRAP,
    PH_RUN
  } hssps_phase_t;

  // Values latched once at reset release.
  typedef struct packed {
    logic i2cMode;
    logic fullPmN;
    logic smbAddrBit1;
  } hssps_strap_t;

  // One push-pull pin seen at a design port.
  typedef struct packed {
    logic out;
    logic oe;
  } hssps_pin_drive_t;

  // Over-current view handed to the hub core.
  typedef struct packed {
    logic port4Active;
    logic gangedActive;
    logic newEvent;
  } hssps_oc_t;

endpackage

//--- core/hssps_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/100ps
`default_nettype none
module hssps_sync #(
  parameter int WIDTH = 1
) (
  // Clock.
  input wire logic clk,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("hssps_sync needs WIDTH of at least one");
  end

  // No reset here: the pins must already be settled through both stages when
  // reset is released, so the strap capture sees a clean level.
  always_ff @(posedge clk) begin
    stage1_r <= asyncIn;
    stage2_r <= stage1_r;
  end

  assign syncOut = stage2_r;

endmodule
`default_nettype wire

//--- dv/hssps_far_side.sv
// Far side of the shared serial pins: open-drain lines with a board pull-up.
`timescale 1ns/100ps
`default_nettype none
module hssps_far_side (
  // Device pull-low enables.
  input wire logic dutClkOe,
  input wire logic dutDatOe,
  // Far side pull-low requests.
  input wire logic farClkLow,
  input wire logic farDatLow,
  // Resolved line levels.
  output logic clkLine,
  output logic datLine
);
  // Either party pulling low wins; a released line rises through the pull-up.
  assign clkLine = !(dutClkOe || farClkLow);
  assign datLine = !(dutDatOe || farDatLow);
endmodule
`default_nettype wire

//--- dv/hssps_pin_select_asserts.sv
// Port-level checker for the pin select block.
`timescale 1ns/100ps
`default_nettype none
module hssps_pin_select_asserts
  import hssps_pkg::*;
#(
  parameter int OTHER_OC = OTHER_OC_INPUTS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Pins.
  input wire logic serialModeSelectNIn,
  input wire logic fullPowerMgmtNIn,
  input wire logic serialModeSelectNOe,
  input wire logic fullPowerMgmtNOe,
  input wire logic sharedSerialClockPinOe,
  input wire logic sharedSerialDataPinOe,
  input wire logic port4OvercurrentN,
  input wire logic [OTHER_OC-1:0] portOvercurrentN,
  // Core side.
  input wire logic eepromClkPullLow,
  input wire logic eepromDatPullLow,
  input wire logic smbusClkPullLow,
  input wire logic smbusDatPullLow,
  input wire logic statusOutputEnable,
  input wire logic gangedEnable,
  // Results.
  input wire logic strapsValid,
  input wire logic i2cModeSelected,
  input wire logic powerSwitchEnabled,
  input wire logic smbusAddrBit1Strap,
  input wire logic port4Overcurrent,
  input wire logic gangedOvercurrent,
  input wire logic overcurrentEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_idle; !strapsValid |-> !sharedSerialClockPinOe && !sharedSerialDataPinOe; endproperty
  a_idle: assert property (p_idle) else $error("serial pin driven before capture");
  property p_clk;
    strapsValid |-> sharedSerialClockPinOe ==
      (i2cModeSelected ? eepromClkPullLow : smbusClkPullLow);
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin routed to wrong side");
  property p_dat;
    strapsValid |-> sharedSerialDataPinOe ==
      (i2cModeSelected ? eepromDatPullLow : smbusDatPullLow);
  endproperty
  a_dat: assert property (p_dat) else $error("data pin routed to wrong side");
  property p_cap; $rose(strapsValid) |-> i2cModeSelected == $past(serialModeSelectNIn, 3)
    && powerSwitchEnabled == !$past(fullPowerMgmtNIn, 3); endproperty
  a_cap: assert property (p_cap) else $error("strap capture wrong");
  property p_hold; strapsValid && $past(strapsValid) |-> $stable(i2cModeSelected)
    && $stable(powerSwitchEnabled) && $stable(smbusAddrBit1Strap); endproperty
  a_hold: assert property (p_hold) else $error("captured strap changed");
  property p_addr;
    strapsValid |-> smbusAddrBit1Strap == (!i2cModeSelected && !powerSwitchEnabled);
  endproperty
  a_addr: assert property (p_addr) else $error("address bit wrong");
  property p_sts; strapsValid && $past(strapsValid)
    |-> serialModeSelectNOe == $past(statusOutputEnable)
    && fullPowerMgmtNOe == $past(statusOutputEnable); endproperty
  a_sts: assert property (p_sts) else $error("status pin enable wrong");
  property p_oc4; (strapsValid && powerSwitchEnabled && !port4OvercurrentN)[*4]
    |-> port4Overcurrent; endproperty
  a_oc4: assert property (p_oc4) else $error("port 4 over-current missed");
  property p_unsup; strapsValid && $past(strapsValid) && !powerSwitchEnabled
    |-> !port4Overcurrent && !gangedOvercurrent; endproperty
  a_unsup: assert property (p_unsup) else $error("over-current while unsupported");
  property p_gang; (strapsValid && powerSwitchEnabled && gangedEnable
    && !(&portOvercurrentN))[*4] |-> gangedOvercurrent; endproperty
  a_gang: assert property (p_gang) else $error("ganged over-current missed");
  property p_ev;
    strapsValid |-> overcurrentEvent == ($rose(port4Overcurrent) || $rose(gangedOvercurrent));
  endproperty
  a_ev: assert property (p_ev) else $error("event pulse wrong");
endmodule
bind hssps_pin_select hssps_pin_select_asserts #(.OTHER_OC(OTHER_OC)) u_chk (.clk, .rst_b,
  .serialModeSelectNIn, .fullPowerMgmtNIn, .serialModeSelectNOe, .fullPowerMgmtNOe,
  .sharedSerialClockPinOe, .sharedSerialDataPinOe, .port4OvercurrentN, .portOvercurrentN,
  .eepromClkPullLow, .eepromDatPullLow, .smbusClkPullLow, .smbusDatPullLow,
  .statusOutputEnable, .gangedEnable, .strapsValid, .i2cModeSelected, .powerSwitchEnabled,
  .smbusAddrBit1Strap, .port4Overcurrent, .gangedOvercurrent, .overcurrentEvent);
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the pin select block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hssps_pkg::*;
  // Row bits: mode pin, power pin, then expected mode, switching and address bit.
  typedef struct packed {logic m, p, i2c, pse, addr;} hssps_row_t;
  hssps_row_t rows [4] = '{5'h16, 5'h1c, 5'h02, 5'h09};
  logic clk, rst_b, modeIn, pmIn, ckLine, dtLine, oc4N, stsEn, gang, susp, conn;
  logic eCk, eDt, sCk, sDt, fCk, fDt, mOut, mOe, pOut, pOe, ckOe, dtOe, eCkS, sCkS, sDtS;
  logic valid, i2c, pse, addr, oc4, ocG, ocEv;
  logic modePin, pmPin, ckOut, dtOut, eDtS;
  logic [OTHER_OC_INPUTS-1:0] ocN;
  int num_errors = 0;
  int tests_run = 0;
  int cnt;
  // Before the first reset edge the enables are unknown; the pad then shows its board level.
  assign modePin = (mOe === 1'h1) ? mOut : modeIn;
  assign pmPin = (pOe === 1'h1) ? pOut : pmIn;
  hssps_pin_select dut (.clk(clk), .rst_b(rst_b),
    .serialModeSelectNIn(modePin), .serialModeSelectNOut(mOut),
    .serialModeSelectNOe(mOe), .fullPowerMgmtNIn(pmPin), .fullPowerMgmtNOut(pOut),
    .fullPowerMgmtNOe(pOe), .sharedSerialClockPinIn(ckLine), .sharedSerialClockPinOut(ckOut),
    .sharedSerialClockPinOe(ckOe), .sharedSerialDataPinIn(dtLine), .sharedSerialDataPinOut(dtOut),
    .sharedSerialDataPinOe(dtOe), .port4OvercurrentN(oc4N), .portOvercurrentN(ocN),
    .eepromClkPullLow(eCk), .eepromDatPullLow(eDt), .eepromClkSeen(eCkS), .eepromDatSeen(eDtS),
    .smbusClkPullLow(sCk), .smbusDatPullLow(sDt), .smbusClkSeen(sCkS), .smbusDatSeen(sDtS),
    .statusOutputEnable(stsEn), .gangedEnable(gang), .upstreamSsSuspended(susp),
    .upstreamSsConnected(conn), .strapsValid(valid), .i2cModeSelected(i2c),
    .powerSwitchEnabled(pse), .smbusAddrBit1Strap(addr), .port4Overcurrent(oc4),
    .gangedOvercurrent(ocG), .overcurrentEvent(ocEv));
  hssps_far_side far (.dutClkOe(ckOe), .dutDatOe(dtOe), .farClkLow(fCk), .farDatLow(fDt),
    .clkLine(ckLine), .datLine(dtLine));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Two cycles of reset: capture reads the pins as they stood at the first reset edge,
  // so the block must not be driving the strap pins when this is called.
  task automatic reboot(input logic m, input logic p);
    rst_b = 1'h0;
    modeIn = m;
    pmIn = p;
    cyc(2);
    chk("valid in reset", valid, 1'h0);
    rst_b = 1'h1;
    cyc(1);
  endtask
  task automatic watch(input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += int'(ocEv === 1'h1);
    end
  endtask
  initial begin
    {eCk, eDt, sCk, sDt, fCk, fDt, stsEn, gang, susp, conn} = 10'h000;
    oc4N = 1'h1;
    ocN = '1;
    foreach (rows[i]) begin
      reboot(rows[i].m, rows[i].p);
      chk("mode", i2c, rows[i].i2c);
      chk("switching", pse, rows[i].pse);
      chk("addr bit", addr, rows[i].addr);
      modeIn = ~modeIn;
      pmIn = ~pmIn;
      eCk = 1'h1;
      sDt = 1'h1;
      fCk = 1'h1;
      fDt = 1'h1;
      cyc(1);
      chk("clock oe", ckOe, rows[i].i2c);
      chk("data oe", dtOe, !rows[i].i2c);
      chk("clock drive level", ckOut, 1'h0);
      chk("data drive level", dtOut, 1'h0);
      cyc(3);
      chk("eeprom clock seen", eCkS, !rows[i].i2c);
      chk("smbus clock seen", sCkS, rows[i].i2c);
      chk("eeprom data seen", eDtS, !rows[i].i2c);
      chk("smbus data seen", sDtS, rows[i].i2c);
      chk("mode held", i2c, rows[i].i2c);
      chk("switching held", pse, rows[i].pse);
      {eCk, sDt, fCk, fDt} = 4'h0;
      $display("row %0d done", i);
    end
    oc4N = 1'h0;
    ocN = '0;
    gang = 1'h1;
    watch(6);
    chk("unsupported oc4", oc4, 1'h0);
    chk("unsupported ganged", ocG, 1'h0);
    chk("unsupported event", cnt == 0, 1'h1);
    $display("unsupported over-current done");
    {oc4N, gang} = 2'h2;
    ocN = '1;
    reboot(1'h1, 1'h0);
    oc4N = 1'h0;
    watch(6);
    chk("oc4 level", oc4, 1'h1);
    chk("one event", cnt == 1, 1'h1);
    oc4N = 1'h1;
    cyc(5);
    chk("oc4 clear", oc4, 1'h0);
    gang = 1'h1;
    ocN[OTHER_OC_INPUTS-1] = 1'h0;
    watch(6);
    chk("ganged level", ocG, 1'h1);
    chk("ganged event", cnt == 1, 1'h1);
    gang = 1'h0;
    cyc(5);
    chk("ganged off", ocG, 1'h0);
    ocN = '1;
    $display("over-current done");
    {stsEn, susp, conn} = 3'h7;
    cyc(2);
    chk("suspend oe", mOe, 1'h1);
    chk("suspend out", mOut, 1'h1);
    chk("connect oe", pOe, 1'h1);
    chk("connect out", pOut, 1'h1);
    {susp, conn} = 2'h0;
    cyc(2);
    chk("suspend low", mOut, 1'h0);
    chk("connect low", pOut, 1'h0);
    chk("mode kept", i2c, 1'h1);
    stsEn = 1'h0;
    cyc(2);
    chk("status off", mOe, 1'h0);
    chk("connect off", pOe, 1'h0);
    $display("status pins done");
    close_out();
  end
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
